// [logic/trip_manager_regs.svh]
// register offsets, field positions, reset values and codes of the trip manager
// assumes word-addressed avalon-mm slave with 32-bit data
`ifndef TRIP_MANAGER_REGS_SVH
`define TRIP_MANAGER_REGS_SVH
`define TM_ADDR_CTRL      4'h0
`define TM_ADDR_STATUS    4'h1
`define TM_ADDR_CODE      4'h2
`define TM_ADDR_REPORT    4'h3
`define TM_ADDR_RESET     4'h4
`define TM_CTRL_MAIN_EN   0
`define TM_CTRL_DISP_EN   1
`define TM_CTRL_LOG_EN    2
`define TM_CTRL_METHOD_LO 3
`define TM_CTRL_RESET     5'h01
`define TM_MAIN_LO        16'd2402
`define TM_MAIN_HI        16'd2436
`define TM_DISP_LO        16'd2501
`define TM_DISP_LOCAL_HI  16'd2531
`define TM_DISP_REMOTE    16'd50
`define TM_LOG_BASE       16'd2601
`define TM_LOG_ATTEMPTS   5'd20
`endif

// [logic/trip_pkg.sv]
// types shared by the trip manager files
// assumes trip_manager_regs.svh is included by users needing numbers
package trip_pkg;
  typedef enum logic [1:0] {
    METHOD_DIGITAL = 2'b00,
    METHOD_DISPLAY = 2'b01,
    METHOD_BUS     = 2'b10
  } method_t;
  typedef enum logic [1:0] {
    GRP_MAIN = 2'b00,
    GRP_DISP = 2'b01,
    GRP_LOG  = 2'b10
  } group_t;
endpackage : trip_pkg

// [logic/trip_fail_if.sv]
// carries logging attempt results from the top to the failure counter
// assumes a single sys_clk domain
`timescale 1ns/1ps
interface trip_fail_if;
  logic       attemptValid;
  logic       attemptFail;
  logic [1:0] attemptKind;
  logic       limitHit;
  logic [1:0] limitKind;
  modport top (output attemptValid, output attemptFail, output attemptKind,
               input limitHit, input limitKind);
  modport cnt (input attemptValid, input attemptFail, input attemptKind,
               output limitHit, output limitKind);
endinterface : trip_fail_if

// [logic/log_fail_counter.sv]
// counts consecutive failed logging attempts per kind
// assumes attempt strobes are on sys_clk
`timescale 1ns/1ps
`include "trip_manager_regs.svh"
module log_fail_counter (
  input wire logic  sys_clk,
  input wire logic  reset,
  trip_fail_if.cnt  fail
);
  typedef struct packed {
    logic [2:0][4:0] count;
    logic            hit;
    logic [1:0]      kind;
  } cnt_state_t;
  cnt_state_t st_r;
  cnt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    if (fail.attemptValid && fail.attemptKind != 2'b11) begin
      if (!fail.attemptFail) begin
        st_nxt.count[fail.attemptKind] = 5'h00;
      end else if (st_r.count[fail.attemptKind] == `TM_LOG_ATTEMPTS - 5'd1) begin
        // limit reached: restart the run so a persisting fault reports again
        st_nxt.count[fail.attemptKind] = 5'h00;
        st_nxt.hit  = 1'b1;
        st_nxt.kind = fail.attemptKind;
      end else begin
        st_nxt.count[fail.attemptKind] = st_r.count[fail.attemptKind] + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fail.limitHit  = st_r.hit;
  assign fail.limitKind = st_r.kind;
endmodule : log_fail_counter

// [logic/fail_safe_trip_manager.sv]
// fail-safe trip latch: codes faults, latches per group, clears by chosen reset source
// assumes reports and bus on sys_clk; resetDin and powerCycle come from pins
// Functional notes
// - main-board failures are reported as codes 2402 to 2436
// - main-board group has an enable, on by default
// - main trip clears only by reset from control-method source
// - control-supply power cycle does not clear a main trip
// - init failures code 2402,2404,2406,2408,2410,2412
// - codes 2426,2428,2430,2432,2436 specific; 2420,2422,2424,2434 general
// - display failures are reported as codes 2501 to 2581
// - display group enable defaults off; off means no latch, display recovers
// - display trip clears by method reset or power cycle
// - local display codes 2501-2529 process, 2530 link, 2531 unresponsive
// - remote display code equals local code plus 50
// - logging failures are reported as codes 2601 to 2603
// - logging enable defaults off; off disables logging on continual failure
// - logging trip clears by method reset or power cycle
// - trip after 20 consecutive failures: 2601 init, 2602 op, 2603 card
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "trip_manager_regs.svh"
module fail_safe_trip_manager (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // avalon-mm slave, word addressed
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // main-board fault report: index 0..14 into the code table
  input  wire logic        mainFault,
  input  wire logic [3:0]  mainIndex,
  // display fault report: local index 0..30, remote flag
  input  wire logic        dispFault,
  input  wire logic [4:0]  dispIndex,
  input  wire logic        dispRemote,
  // logging attempt results: kind 0 init, 1 operation, 2 card
  input  wire logic        logAttempt,
  input  wire logic        logFailed,
  input  wire logic [1:0]  logKind,
  // digital reset pin and control-supply restore pulse from the supervisor
  input  wire logic        resetDin,
  input  wire logic        powerCycle,
  // display reset request from the operator display
  input  wire logic        displayReset,
  output logic             tripActive,
  output logic      [15:0] tripCode,
  output logic             displayRecover,
  output logic             loggingDisabled
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        mainEn;
    logic        dispEn;
    logic        logEn;
    trip_pkg::method_t method;
    logic        latched;
    trip_pkg::group_t group;
    logic [15:0] code;
    logic        recover;
    logic        logOff;
    logic [15:0] lastReport;
    logic [2:0]  dinSync;
    logic [1:0]  pwrSync;
    logic        pwrPrev;
    logic        busReset;
    logic        ack;
    logic [31:0] rdata;
  } top_state_t;
  top_state_t st_r;
  top_state_t st_nxt;

  trip_fail_if fail ();

  log_fail_counter u_counter (
    .sys_clk (sys_clk),
    .reset   (reset),
    .fail    (fail)
  );

  assign fail.attemptValid = logAttempt;
  assign fail.attemptFail  = logFailed;
  assign fail.attemptKind  = logKind;

  ////////////////////////////////////////////////////////////////////////////
  // main-board code table
  function automatic logic [15:0] mainCode(input logic [3:0] idx);
    logic [15:0] c;
    c = 16'h0000;
    unique case (idx)
      4'h0:    c = `TM_MAIN_LO;
      4'h1:    c = `TM_MAIN_LO + 16'd2;
      4'h2:    c = `TM_MAIN_LO + 16'd4;
      4'h3:    c = `TM_MAIN_LO + 16'd6;
      4'h4:    c = `TM_MAIN_LO + 16'd8;
      4'h5:    c = `TM_MAIN_LO + 16'd10;
      4'h6:    c = `TM_MAIN_LO + 16'd18;       // general 2420
      4'h7:    c = `TM_MAIN_LO + 16'd20;       // general 2422
      4'h8:    c = `TM_MAIN_LO + 16'd22;       // general 2424
      4'h9:    c = `TM_MAIN_LO + 16'd24;       // display link
      4'ha:    c = `TM_MAIN_LO + 16'd26;       // modbus
      4'hb:    c = `TM_MAIN_LO + 16'd28;       // parameter save
      4'hc:    c = `TM_MAIN_LO + 16'd30;       // logging
      4'hd:    c = `TM_MAIN_LO + 16'd32;       // general 2434
      default: c = `TM_MAIN_HI;                // fieldbus module, out-of-table too
    endcase
    return c;
  endfunction : mainCode

  // local indices above the table clamp to the unresponsive code
  function automatic logic [15:0] dispCode(input logic [4:0] idx, input logic remote);
    logic [15:0] c;
    c = `TM_DISP_LO + {11'h000, idx};
    if (c > `TM_DISP_LOCAL_HI) begin
      c = `TM_DISP_LOCAL_HI;
    end
    if (remote) begin
      c = c + `TM_DISP_REMOTE;
    end
    return c;
  endfunction : dispCode

  ////////////////////////////////////////////////////////////////////////////
  logic        accRd;
  logic        accWr;
  logic        pwrEvent;
  logic        methodReset;
  logic        clearNow;

  always_comb begin
    st_nxt = st_r;
    accRd = read && !st_r.ack;
    accWr = write && !st_r.ack;
    st_nxt.ack = (read || write) && !st_r.ack;
    st_nxt.busReset = 1'b0;
    st_nxt.recover = 1'b0;

    // pin synchronisers; only the later stages are looked at
    st_nxt.dinSync = {st_r.dinSync[1:0], resetDin};
    st_nxt.pwrSync = {st_r.pwrSync[0], powerCycle};
    st_nxt.pwrPrev = st_r.pwrSync[1];
    pwrEvent = st_r.pwrSync[1] && !st_r.pwrPrev;

    unique case (st_r.method)
      trip_pkg::METHOD_DIGITAL: methodReset = st_r.dinSync[1] && !st_r.dinSync[2];
      trip_pkg::METHOD_DISPLAY: methodReset = displayReset;
      trip_pkg::METHOD_BUS:     methodReset = st_r.busReset;
      default:                  methodReset = 1'b0;
    endcase

    // main trip ignores the power cycle, other groups accept it
    clearNow = st_r.latched && (methodReset ||
               (pwrEvent && st_r.group != trip_pkg::GRP_MAIN));
    if (clearNow) begin
      st_nxt.latched = 1'b0;
      st_nxt.code = 16'h0000;
    end

    // logging comes back on a bus reset command or a power cycle; a failure run
    // ending in the same cycle must win, so the clear is applied before the set
    if (st_r.busReset || pwrEvent) begin
      st_nxt.logOff = 1'b0;
    end

    // fault capture; a held trip keeps its code, and a report during a held trip updates lastReport, plus recover or logOff when its group is off
    if (mainFault) begin
      st_nxt.lastReport = mainCode(mainIndex);
      if (st_r.mainEn && !st_r.latched) begin
        st_nxt.latched = 1'b1;
        st_nxt.group = trip_pkg::GRP_MAIN;
        st_nxt.code = mainCode(mainIndex);
      end
    end else if (dispFault) begin
      st_nxt.lastReport = dispCode(dispIndex, dispRemote);
      if (st_r.dispEn && !st_r.latched) begin
        st_nxt.latched = 1'b1;
        st_nxt.group = trip_pkg::GRP_DISP;
        st_nxt.code = dispCode(dispIndex, dispRemote);
      end else if (!st_r.dispEn) begin
        st_nxt.recover = 1'b1;
      end
    end else if (fail.limitHit) begin
      st_nxt.lastReport = `TM_LOG_BASE + {14'h0000, fail.limitKind};
      if (st_r.logEn && !st_r.latched) begin
        st_nxt.latched = 1'b1;
        st_nxt.group = trip_pkg::GRP_LOG;
        st_nxt.code = `TM_LOG_BASE + {14'h0000, fail.limitKind};
      end else if (!st_r.logEn) begin
        st_nxt.logOff = 1'b1;
      end
    end
    // register writes
    if (accWr && byteenable[0]) begin
      unique case (address)
        `TM_ADDR_CTRL: begin
          st_nxt.mainEn = writedata[`TM_CTRL_MAIN_EN];
          st_nxt.dispEn = writedata[`TM_CTRL_DISP_EN];
          st_nxt.logEn  = writedata[`TM_CTRL_LOG_EN];
          if (writedata[`TM_CTRL_METHOD_LO +: 2] != 2'b11) begin
            st_nxt.method = trip_pkg::method_t'(writedata[`TM_CTRL_METHOD_LO +: 2]);
          end
        end
        `TM_ADDR_RESET: st_nxt.busReset = writedata[0];
        default: ;
      endcase
    end

    st_nxt.rdata = 32'h0000_0000;
    if (accRd) begin
      unique case (address)
        `TM_ADDR_CTRL:   st_nxt.rdata = {27'h0000000, st_r.method, st_r.logEn,
                                         st_r.dispEn, st_r.mainEn};
        `TM_ADDR_STATUS: st_nxt.rdata = {28'h0000000, st_r.logOff, st_r.group,
                                         st_r.latched};
        `TM_ADDR_CODE:   st_nxt.rdata = {16'h0000, st_r.code};
        `TM_ADDR_REPORT: st_nxt.rdata = {16'h0000, st_r.lastReport};
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.mainEn <= 1'b1;
      st_r.group  <= trip_pkg::GRP_MAIN;
      st_r.method <= trip_pkg::METHOD_DIGITAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign readdata        = st_r.rdata;
  assign waitrequest     = !st_r.ack;
  assign tripActive      = st_r.latched;
  assign tripCode        = st_r.code;
  assign displayRecover  = st_r.recover;
  assign loggingDisabled = st_r.logOff;
endmodule : fail_safe_trip_manager

// [tb/trip_monitor.sv]
// checker on the trip manager ports
// assumes one sys_clk domain with synchronous reset
`timescale 1ns/1ps
module trip_monitor (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic        mainFault,
  input wire logic [3:0]  mainIndex,
  input wire logic        dispFault,
  input wire logic [4:0]  dispIndex,
  input wire logic        dispRemote,
  input wire logic        powerCycle,
  input wire logic        tripActive,
  input wire logic [15:0] tripCode,
  input wire logic        displayRecover
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_dispTaken;
    dispFault && !mainFault && !tripActive ##1 tripActive;
  endsequence
  ////////////////////////////////////////
  a_bus_answer: assert property ((read || write) && waitrequest |=> s_answer)
    else $error("bus answer late or too long");
  a_main_code: assert property (mainFault && !tripActive && mainIndex < 4'h6
    |=> tripCode == 16'd2402 + 16'($past(mainIndex)) * 16'd2) else $error("main code wrong");
  a_disp_code: assert property (s_dispTaken |-> tripCode ==
    ($past(dispIndex) > 5'd30 ? 16'd2531 : 16'd2501 + 16'($past(dispIndex)))
    + ($past(dispRemote) ? 16'd50 : 16'd0)) else $error("display code wrong");
  a_hold_code: assert property (tripActive && $stable(tripActive) |-> $stable(tripCode))
    else $error("latched code moved");
  a_idle_zero: assert property (!tripActive |-> tripCode == 16'h0000)
    else $error("code without trip");
  a_recover_cause: assert property (displayRecover |-> $past(dispFault))
    else $error("recover without fault");
  a_power_keeps: assert property (tripActive && tripCode <= 16'd2436 && $rose(powerCycle)
    |=> tripActive [*6]) else $error("main trip lost on power");
  a_power_clears: assert property (tripActive && tripCode >= 16'd2501 && $rose(powerCycle)
    |-> ##[1:8] !tripActive) else $error("power did not clear");
endmodule : trip_monitor
bind fail_safe_trip_manager trip_monitor trip_monitor_i (.sys_clk, .reset, .read, .write,
  .waitrequest, .mainFault, .mainIndex, .dispFault, .dispIndex, .dispRemote, .powerCycle,
  .tripActive, .tripCode, .displayRecover);

// [tb/reset_source_model.sv]
// operator side: digital reset pin and display reset button
// assumes requests come as one-cycle strobes on sys_clk
`timescale 1ns/1ps
module reset_source_model #(parameter int HOLD = 4) (
  input  wire logic sys_clk,
  input  wire logic pressDin,
  input  wire logic pressDisp,
  output logic      resetDin,
  output logic      displayReset
);
  int cnt = 0;
  ////////////////////////////////////////
  // pin stays up several cycles, like a slow push button
  always @(posedge sys_clk) begin
    if (pressDin) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    displayReset <= pressDisp;
  end
  assign resetDin = cnt > 0;
endmodule : reset_source_model

// [tb/testbench.sv]
// self-checking bench for the trip manager
// assumes design files under logic/ and the reset source model
`timescale 1ns/1ps
`include "trip_manager_regs.svh"
module testbench;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] q;
  logic        mainFault = 1'b0;
  logic [3:0]  mainIndex = 4'h0;
  logic        dispFault = 1'b0;
  logic [4:0]  dispIndex = 5'h00;
  logic        dispRemote = 1'b0;
  logic        logAttempt = 1'b0;
  logic        logFailed = 1'b0;
  logic [1:0]  logKind = 2'h0;
  logic        pressDin = 1'b0;
  logic        pressDisp = 1'b0;
  logic        powerCycle = 1'b0;
  logic        waitrequest, resetDin, displayReset, displayRecover, loggingDisabled;
  logic        tripActive;
  logic [15:0] tripCode;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  always #10 sys_clk = ~sys_clk;
  fail_safe_trip_manager fail_safe_trip_manager_i (.sys_clk, .reset, .address, .read, .write,
    .writedata, .byteenable(4'hf), .readdata, .waitrequest, .mainFault, .mainIndex, .dispFault,
    .dispIndex, .dispRemote, .logAttempt, .logFailed, .logKind, .resetDin, .powerCycle,
    .displayReset, .tripActive, .tripCode, .displayRecover, .loggingDisabled);
  reset_source_model reset_source_model_i (.sys_clk, .pressDin, .pressDisp, .resetDin,
    .displayReset);
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic pulse(input int what, input logic [4:0] i, input logic r);
    @(posedge sys_clk);
    mainFault <= what == 0;
    dispFault <= what == 1;
    pressDin <= what == 2;
    pressDisp <= what == 3;
    powerCycle <= what == 4;
    mainIndex <= i[3:0];
    dispIndex <= i;
    dispRemote <= r;
    logAttempt <= what >= 5;
    logFailed <= what == 6;
    logKind <= i[1:0];
    // power stays up long enough for the pin synchroniser
    repeat (what == 4 ? 6 : 1) @(posedge sys_clk);
    {mainFault, dispFault, pressDin, pressDisp, powerCycle, logAttempt} <= 6'h00;
    @(negedge sys_clk);
  endtask : pulse
  task automatic waitTrip(input logic v);
    repeat (12) if (tripActive !== v) @(negedge sys_clk);
    check("tripActive", v, tripActive);
  endtask : waitTrip
  ////////////////////////////////////////
  task automatic t_defaults;
    bus(1'b0, `TM_ADDR_CTRL, 32'h0);
    check("ctrl", 32'h00000001, q);
    bus(1'b0, 4'hf, 32'h0);
    check("unmapped", 32'h0, q);
  endtask : t_defaults
  task automatic t_main;
    logic [15:0] e;
    for (int i = 0; i < 15; i++) begin
      e = i < 6 ? 16'd2402 + 16'(2 * i) : i < 14 ? 16'd2420 + 16'(2 * (i - 6)) : 16'd2436;
      pulse(0, 5'(i), 1'b0);
      check("mainCode", e, tripCode);
      pulse(0, 5'h0f, 1'b0);
      bus(1'b0, `TM_ADDR_REPORT, 32'h0);
      check("report", 32'd2436, q);
      pulse(4, 5'h00, 1'b0);
      pulse(3, 5'h00, 1'b0);
      bus(1'b0, `TM_ADDR_CODE, 32'h0);
      check("codeReg", 32'(e), q);
      check("mainHeld", e, tripCode);
      pulse(2, 5'h00, 1'b0);
      waitTrip(1'b0);
    end
  endtask : t_main
  task automatic t_disp;
    logic [4:0] ix;
    pulse(1, 5'd3, 1'b0);
    check("recover", 1'b1, displayRecover);
    check("noLatch", 1'b0, tripActive);
    bus(1'b1, `TM_ADDR_CTRL, 32'h0000000f);
    for (int i = 0; i < 8; i++) begin
      ix = i[1:0] == 2'h0 ? 5'd0 : 5'd28 + 5'(i[1:0]);
      pulse(1, ix, i[2]);
      check("dispCode", (ix > 5'd30 ? 16'd2531 : 16'd2501 + 16'(ix))
        + (i[2] ? 16'd50 : 16'd0), tripCode);
      pulse(i[0] ? 4 : 3, 5'h00, 1'b0);
      waitTrip(1'b0);
    end
  endtask : t_disp
  task automatic t_log;
    bus(1'b1, `TM_ADDR_CTRL, 32'h00000017);
    for (int k = 0; k < 3; k++) begin
      repeat (19) pulse(6, 5'(k), 1'b0);
      pulse(5, 5'(k), 1'b0);
      repeat (19) pulse(6, 5'(k), 1'b0);
      repeat (3) @(negedge sys_clk);
      check("noTrip", 1'b0, tripActive);
      pulse(6, 5'(k), 1'b0);
      waitTrip(1'b1);
      check("logCode", 16'd2601 + 16'(k), tripCode);
      bus(1'b0, `TM_ADDR_STATUS, 32'h0);
      check("status", 32'h00000005, q);
      bus(1'b1, `TM_ADDR_RESET, 32'h1);
      waitTrip(1'b0);
    end
    bus(1'b1, `TM_ADDR_CTRL, 32'h00000013);
    repeat (20) pulse(6, 5'd1, 1'b0);
    repeat (3) @(negedge sys_clk);
    check("logOff", 1'b1, loggingDisabled);
    check("logNoTrip", 1'b0, tripActive);
    bus(1'b1, `TM_ADDR_CTRL, 32'h00000010);
    pulse(0, 5'd9, 1'b0);
    check("mainOff", 1'b0, tripActive);
    bus(1'b0, `TM_ADDR_REPORT, 32'h0);
    check("report", 32'd2426, q);
  endtask : t_log
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_defaults;
    t_main;
    t_disp;
    t_log;
    end_of_test;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_of_test;
    end
  end
endmodule : testbench
